// ### core/qei_core.sv
// Notes on behaviour
// - Count up on AB moving 10-11, 00-10, 11-01, 01-00.
// - Count down on 01-11, 11-10, 00-01, 10-00; report direction.
// - Unchanged pair gives no pulse and keeps direction.
// - Both phases changing at once is invalid; count and direction untouched.
// - Every valid state change yields one count pulse, four per line.
// - Direction held in a flop, readable as status.
// - Up/down counter accumulates pulses into position.
// - Phase A, phase B, index and home pass a software-configured digital noise filter; the gate input is unfiltered.
// - Inputs are phase A, phase B, index, home and gate.
// - Index pulse can reset the position counter.
// - 32-bit counter tallies index pulses.
// - 32-bit register preloads position and captures it.
// - Two 32-bit compare thresholds, less-than and greater-than.
// - Mode as general 32-bit timer.
// - Mode with external count pulse and direction inputs.
// - Gated count mode counts only while gate active.
// - Gated timer mode times while gate active.
// - Interrupt requests on decoder and counter events.
//
// The APB slave port and the register addresses were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none

module qei_core
    import qei_pkg::*;
#(
    parameter int FILT_MAX_W = FILT_W
)
(
    input wire logic clock,
    input wire logic reset,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire qei_pins_s pins,
    input wire logic gateIn,
    output qei_irq_s irq,
    output logic countDir
);

    // The filter field is FILT_W bits wide; a wider count would spill into the velocity clear bit
    if (FILT_MAX_W < 1 || FILT_MAX_W > FILT_W)
    begin : g_filtChk
        $error("qei_core: FILT_MAX_W out of range");
    end

    // ----------------------------------------
    // Registers
    // ----------------------------------------
    logic [31:0] ctrl_reg;
    logic [31:0] pos_reg, init_reg, idxCnt_reg, vel_reg, tmr_reg;
    logic [31:0] cmpLo_reg, cmpHi_reg, intvl_reg, intvlRun_reg;
    logic [6:0] stat_reg;
    logic dir_reg;
    logic [1:0] prevAB_reg;
    logic idxPrev_reg, homePrev_reg, gatePrev_reg;
    logic [3:0] filt_reg;
    logic [FILT_MAX_W-1:0] filtCnt_reg [4];

    qei_mode_e mode;
    logic enable;
    logic [FILT_MAX_W-1:0] filtLen;
    assign mode = qei_mode_e'(ctrl_reg[CTRL_MODE_LSB +: 3]);
    assign enable = ctrl_reg[CTRL_EN_BIT];
    assign filtLen = ctrl_reg[CTRL_FILT_LSB +: FILT_MAX_W];

    logic wrAcc, rdSetup;
    assign wrAcc = psel && penable && pwrite;
    // Read data is taken in the setup cycle, so read side effects belong there too
    assign rdSetup = psel && !penable && !pwrite;

    // ----------------------------------------
    // Noise filter
    // ----------------------------------------
    // A level passes once it has stood filtLen+1 cycles; filtLen zero is pass-through with one stage.
    logic [3:0] rawIn;
    assign rawIn = {pins.phaseA, pins.phaseB, pins.index, pins.home};
    always_ff @(posedge clock)
    begin
        for (int i = 0; i < 4; i++)
        begin
            if (reset)
            begin
                filt_reg[i] <= 1'b0;
                filtCnt_reg[i] <= '0;
            end
            else if (rawIn[i] == filt_reg[i])
                filtCnt_reg[i] <= '0;
            else if (filtCnt_reg[i] >= filtLen)
            begin
                filt_reg[i] <= rawIn[i];
                filtCnt_reg[i] <= '0;
            end
            else
                filtCnt_reg[i] <= filtCnt_reg[i] + 1'b1;
        end
    end

    logic [1:0] curAB;
    logic idxF, homeF;
    assign curAB = filt_reg[3:2];
    assign idxF = filt_reg[1];
    assign homeF = filt_reg[0];

    // ----------------------------------------
    // Quadrature decode
    // ----------------------------------------
    function automatic logic [1:0] quadStep(input logic [1:0] cur, input logic [1:0] prev);
        // Returns {valid, up}
        case ({cur, prev})
            4'b1110, 4'b1000, 4'b0111, 4'b0001: quadStep = 2'b11;
            4'b1101, 4'b1011, 4'b0100, 4'b0010: quadStep = 2'b10;
            default: quadStep = 2'b00;
        endcase
    endfunction : quadStep

    logic [1:0] step;
    logic idxRise, homeRise, gateRise;
    logic cntPulse, cntUp, tmrTick;
    assign step = quadStep(curAB, prevAB_reg);
    assign idxRise = idxF && !idxPrev_reg;
    assign homeRise = homeF && !homePrev_reg;
    assign gateRise = gateIn && !gatePrev_reg;

    always_comb
    begin
        cntPulse = 1'b0;
        cntUp = dir_reg;
        tmrTick = 1'b0;
        case (mode)
            QEI_MODE_QUAD:
            begin
                cntPulse = step[1];
                cntUp = step[0];
            end
            QEI_MODE_EXTUD:
            begin
                // Phase A carries the count strobe, phase B the direction
                cntPulse = curAB[1] && !prevAB_reg[1];
                cntUp = curAB[0];
            end
            QEI_MODE_GATECNT:
            begin
                cntPulse = gateIn && curAB[1] && !prevAB_reg[1];
                cntUp = 1'b1;
            end
            QEI_MODE_GATETMR: tmrTick = gateIn;
            QEI_MODE_TIMER: tmrTick = 1'b1;
            default: ;
        endcase
        if (!enable)
        begin
            cntPulse = 1'b0;
            tmrTick = 1'b0;
        end
    end

    always_ff @(posedge clock)
    begin
        if (reset)
        begin
            prevAB_reg <= 2'b00;
            idxPrev_reg <= 1'b0;
            homePrev_reg <= 1'b0;
            gatePrev_reg <= 1'b0;
        end
        else
        begin
            prevAB_reg <= curAB;
            idxPrev_reg <= idxF;
            homePrev_reg <= homeF;
            gatePrev_reg <= gateIn;
        end
    end

    always_ff @(posedge clock)
    begin
        if (reset)
            dir_reg <= 1'b0;
        else if (cntPulse)
            dir_reg <= cntUp;
    end

    // ----------------------------------------
    // Counters
    // ----------------------------------------
    logic cmdLoad, cmdCapt, cmdStClr;
    assign cmdLoad = wrAcc && paddr == CMD_OFS && pwdata[CMD_LOAD_BIT];
    assign cmdCapt = wrAcc && paddr == CMD_OFS && pwdata[CMD_CAPT_BIT];
    assign cmdStClr = wrAcc && paddr == CMD_OFS && pwdata[CMD_STCLR_BIT];

    always_ff @(posedge clock)
    begin
        if (reset)
            pos_reg <= '0;
        else if (cmdLoad)
            pos_reg <= init_reg;
        else if (enable && idxRise && ctrl_reg[CTRL_IDXRST_BIT])
            pos_reg <= '0;
        else if (cntPulse)
            pos_reg <= cntUp ? pos_reg + 32'h0000_0001 : pos_reg - 32'h0000_0001;
    end

    always_ff @(posedge clock)
    begin
        if (reset)
            init_reg <= '0;
        else if (cmdCapt || (enable && homeRise))
            init_reg <= pos_reg;
        else if (wrAcc && paddr == INIT_OFS)
            init_reg <= pwdata;
    end

    always_ff @(posedge clock)
    begin
        if (reset)
            idxCnt_reg <= '0;
        else if (wrAcc && paddr == IDXCNT_OFS)
            idxCnt_reg <= pwdata;
        else if (enable && idxRise)
            idxCnt_reg <= idxCnt_reg + 32'h0000_0001;
    end

    // Velocity is signed; with the control bit set, each software read of it clears it, once per sample interval
    always_ff @(posedge clock)
    begin
        if (reset)
            vel_reg <= '0;
        else if (rdSetup && paddr == VEL_OFS && ctrl_reg[CTRL_VELCLR_BIT])
            vel_reg <= cntPulse ? (cntUp ? 32'h0000_0001 : 32'hFFFF_FFFF) : 32'h0000_0000;
        else if (cntPulse)
            vel_reg <= cntUp ? vel_reg + 32'h0000_0001 : vel_reg - 32'h0000_0001;
    end

    always_ff @(posedge clock)
    begin
        if (reset)
            tmr_reg <= '0;
        else if (wrAcc && paddr == TMR_OFS)
            tmr_reg <= pwdata;
        else if (mode == QEI_MODE_GATETMR && enable && gateRise)
            tmr_reg <= 32'h0000_0001;
        else if (tmrTick)
            tmr_reg <= tmr_reg + 32'h0000_0001;
    end

    // Interval timer: cycles since last count pulse, latched at each pulse
    always_ff @(posedge clock)
    begin
        if (reset)
        begin
            intvlRun_reg <= '0;
            intvl_reg <= '0;
        end
        else if (enable && mode == QEI_MODE_INTVL)
        begin
            if (step[1])
            begin
                intvl_reg <= intvlRun_reg;
                intvlRun_reg <= 32'h0000_0001;
            end
            else
                intvlRun_reg <= intvlRun_reg + 32'h0000_0001;
        end
    end

    // ----------------------------------------
    // Compare and status
    // ----------------------------------------
    logic ltHit, gtHit, errHit;
    assign ltHit = $signed(pos_reg) < $signed(cmpLo_reg);
    assign gtHit = $signed(pos_reg) > $signed(cmpHi_reg);
    assign errHit = enable && mode == QEI_MODE_QUAD && curAB != prevAB_reg && !step[1];

    // Sticky bits: a new event wins over a clear in the same cycle
    logic [6:0] setBits;
    always_comb
    begin
        setBits = '0;
        setBits[ST_LT_BIT] = enable && ltHit;
        setBits[ST_GT_BIT] = enable && gtHit;
        setBits[ST_IDX_BIT] = enable && idxRise;
        setBits[ST_ERR_BIT] = errHit;
        setBits[ST_HOME_BIT] = enable && homeRise;
        setBits[ST_CNTEV_BIT] = tmrTick && tmr_reg == 32'hFFFF_FFFF;
    end

    always_ff @(posedge clock)
    begin
        if (reset)
            stat_reg <= '0;
        else
            stat_reg <= (cmdStClr ? 7'h00 : stat_reg) | setBits;
    end

    always_ff @(posedge clock)
    begin
        if (reset)
            irq <= '0;
        else
        begin
            irq.qeiEvent <= |stat_reg[ST_HOME_BIT:ST_IDX_BIT];
            irq.cntEvent <= stat_reg[ST_LT_BIT] | stat_reg[ST_GT_BIT] | stat_reg[ST_CNTEV_BIT];
        end
    end

    always_ff @(posedge clock)
    begin
        if (reset)
            countDir <= 1'b0;
        else
            countDir <= cntPulse ? cntUp : dir_reg;
    end

    // ----------------------------------------
    // APB slave
    // ----------------------------------------
    always_ff @(posedge clock)
    begin
        if (reset)
        begin
            ctrl_reg <= CTRL_RESET;
            cmpLo_reg <= '0;
            cmpHi_reg <= '0;
        end
        else if (wrAcc)
        begin
            case (paddr)
                CTRL_OFS: ctrl_reg <= pwdata;
                CMPLO_OFS: cmpLo_reg <= pwdata;
                CMPHI_OFS: cmpHi_reg <= pwdata;
                default: ;
            endcase
        end
    end

    logic mapped;
    always_comb
    begin
        case (paddr)
            CTRL_OFS, STAT_OFS, POS_OFS, INIT_OFS, IDXCNT_OFS, VEL_OFS, TMR_OFS,
            CMPLO_OFS, CMPHI_OFS, INTVL_OFS, CMD_OFS: mapped = 1'b1;
            default: mapped = 1'b0;
        endcase
    end

    // Zero wait states: pready rises in the access cycle itself
    always_ff @(posedge clock)
    begin
        if (reset)
        begin
            prdata <= '0;
            pready <= 1'b0;
            pslverr <= 1'b0;
        end
        else
        begin
            pready <= psel && !penable;
            pslverr <= psel && !penable && !mapped;
            if (psel && !penable && !pwrite)
            begin
                case (paddr)
                    CTRL_OFS: prdata <= ctrl_reg;
                    STAT_OFS: prdata <= {25'h0, stat_reg[6:1], dir_reg};
                    POS_OFS: prdata <= pos_reg;
                    INIT_OFS: prdata <= init_reg;
                    IDXCNT_OFS: prdata <= idxCnt_reg;
                    VEL_OFS: prdata <= vel_reg;
                    TMR_OFS: prdata <= tmr_reg;
                    CMPLO_OFS: prdata <= cmpLo_reg;
                    CMPHI_OFS: prdata <= cmpHi_reg;
                    INTVL_OFS: prdata <= intvl_reg;
                    default: prdata <= 32'h0000_0000;
                endcase
            end
        end
    end

endmodule : qei_core

`default_nettype wire

// ### core/qei_pkg.sv
package qei_pkg;

    // ----------------------------------------
    // Register byte offsets
    // ----------------------------------------
    localparam logic [7:0] CTRL_OFS = 8'h00;
    localparam logic [7:0] STAT_OFS = 8'h04;
    localparam logic [7:0] POS_OFS = 8'h08;
    localparam logic [7:0] INIT_OFS = 8'h0C;
    localparam logic [7:0] IDXCNT_OFS = 8'h10;
    localparam logic [7:0] VEL_OFS = 8'h14;
    localparam logic [7:0] TMR_OFS = 8'h18;
    localparam logic [7:0] CMPLO_OFS = 8'h1C;
    localparam logic [7:0] CMPHI_OFS = 8'h20;
    localparam logic [7:0] INTVL_OFS = 8'h24;
    localparam logic [7:0] CMD_OFS = 8'h28;

    // ----------------------------------------
    // Control fields
    // ----------------------------------------
    localparam int CTRL_EN_BIT = 0;
    localparam int CTRL_MODE_LSB = 1;
    localparam int CTRL_IDXRST_BIT = 4;
    localparam int CTRL_FILT_LSB = 8;
    localparam int CTRL_VELCLR_BIT = 16;
    localparam logic [31:0] CTRL_RESET = 32'h0000_0000;

    // Command bits, write-one pulses
    localparam int CMD_LOAD_BIT = 0;
    localparam int CMD_CAPT_BIT = 1;
    localparam int CMD_STCLR_BIT = 2;

    // Status bits
    localparam int ST_DIR_BIT = 0;
    localparam int ST_LT_BIT = 1;
    localparam int ST_GT_BIT = 2;
    localparam int ST_IDX_BIT = 3;
    localparam int ST_ERR_BIT = 4;
    localparam int ST_HOME_BIT = 5;
    localparam int ST_CNTEV_BIT = 6;

    localparam int FILT_W = 8;

    typedef enum logic [2:0] {
        QEI_MODE_QUAD,
        QEI_MODE_EXTUD,
        QEI_MODE_GATECNT,
        QEI_MODE_GATETMR,
        QEI_MODE_TIMER,
        QEI_MODE_INTVL
    } qei_mode_e;

    typedef struct packed {
        logic phaseA;
        logic phaseB;
        logic index;
        logic home;
    } qei_pins_s;

    typedef struct packed {
        logic qeiEvent;
        logic cntEvent;
    } qei_irq_s;

endpackage : qei_pkg

// ### tb/qei_core_props.sv
`timescale 1ns/1ps
`default_nettype none
module qei_core_props
    import qei_pkg::*;
#(
    parameter int FILT_MAX_W = FILT_W
)
(
    input wire logic clock,
    input wire logic reset,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire qei_pins_s pins,
    input wire logic gateIn,
    input wire qei_irq_s irq,
    input wire logic countDir
);
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (reset);
    // ----------------
    // Quiet phase counter, long enough to outlast the widest filter
    // ----------------
    logic [1:0] abPrev;
    logic [8:0] quietCnt;
    always_ff @(posedge clock)
    begin
        abPrev <= {pins.phaseA, pins.phaseB};
        if (reset || abPrev != {pins.phaseA, pins.phaseB})
            quietCnt <= 9'h000;
        else if (quietCnt != 9'h1FF)
            quietCnt <= quietCnt + 9'h001;
    end
    sequence s_setup;
        psel && !penable;
    endsequence
    sequence s_rd(logic [7:0] a);
        pready && !pwrite && paddr == a;
    endsequence
    property p_ready_one;
        s_setup |=> pready;
    endproperty
    property p_ready_pulse;
        pready |=> !pready;
    endproperty
    property p_err_unmapped;
        pready && paddr > CMD_OFS |-> pslverr && (pwrite || prdata == 32'h0);
    endproperty
    property p_no_err;
        pready && paddr <= CMD_OFS && paddr[1:0] == 2'h0 |-> !pslverr;
    endproperty
    property p_cmd_zero;
        s_rd(CMD_OFS) |-> prdata == 32'h0;
    endproperty
    property p_stat_dir;
        s_rd(STAT_OFS) ##0 $stable(countDir) |-> prdata[ST_DIR_BIT] == countDir;
    endproperty
    property p_dir_hold;
        quietCnt > 9'd300 |=> $stable(countDir);
    endproperty
    property p_rst;
        disable iff (1'b0) reset |=> !countDir && irq == 2'h0;
    endproperty
    a_ready_one: assert property (p_ready_one) else $error("no ready after setup");
    a_ready_pulse: assert property (p_ready_pulse) else $error("ready longer than one cycle");
    a_err_unmapped: assert property (p_err_unmapped) else $error("unmapped access not refused");
    a_no_err: assert property (p_no_err) else $error("mapped access refused");
    a_cmd_zero: assert property (p_cmd_zero) else $error("command word reads nonzero");
    a_stat_dir: assert property (p_stat_dir) else $error("status direction differs from pin");
    a_dir_hold: assert property (p_dir_hold) else $error("direction moved with quiet phases");
    a_rst: assert property (p_rst) else $error("outputs not cleared by reset");
endmodule : qei_core_props
bind qei_core qei_core_props #(.FILT_MAX_W(FILT_MAX_W)) qei_core_props_i (.clock, .reset, .psel, .penable,
    .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .pins, .gateIn, .irq, .countDir);
`default_nettype wire

// ### tb/qei_enc_model.sv
`timescale 1ns/1ps
`default_nettype none
module qei_enc_model
    import qei_pkg::*;
(
    input wire logic clock,
    input wire logic stepReq,
    input wire logic stepUp,
    input wire logic jumpReq,
    input wire logic idxReq,
    input wire logic homeReq,
    output qei_pins_s pins
);
    logic [1:0] ab;
    initial ab = 2'h0;
    // Jump flips both phases, a fault only commanded on purpose
    always @(posedge clock)
    begin
        if (jumpReq)
            ab <= ~ab;
        else if (stepReq)
            ab <= stepUp ? {~ab[0], ab[1]} : {ab[0], ~ab[1]};
    end
    assign pins = {ab[1], ab[0], idxReq, homeReq};
endmodule : qei_enc_model
`default_nettype wire

// ### tb/testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench;
    import qei_pkg::*;
    logic clock = 0, reset = 1, psel = 0, penable = 0, pwrite = 0, stepReq = 0, stepUp = 0;
    logic jumpReq = 0, idxReq = 0, homeReq = 0, gateIn = 0, pready, pslverr, countDir, up;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, rd, r1, pos = 32'h0, vel = 32'h0, lfsr = 32'hB7E0;
    int error_cnt = 0, n_tests = 0, gap = 5, i;
    qei_pins_s pins;
    qei_irq_s irq;
    qei_core qei_core_i (.clock(clock), .reset(reset), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .pins(pins),
        .gateIn(gateIn), .irq(irq), .countDir(countDir));
    qei_enc_model qei_enc_model_i (.clock(clock), .stepReq(stepReq), .stepUp(stepUp), .jumpReq(jumpReq),
        .idxReq(idxReq), .homeReq(homeReq), .pins(pins));
    initial
    begin
        forever #20 clock = ~clock;
    end
    // ----------------
    // Helpers
    // ----------------
    function automatic logic [31:0] nxt(input logic [31:0] p, input logic u);
        return u ? p + 32'h1 : p - 32'h1;
    endfunction : nxt
    function automatic logic [31:0] rnd(input logic [31:0] x);
        return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
    endfunction : rnd
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("[FAIL] %0t got %h exp %h", $time, got, exp);
        end
    endtask : check
    task automatic give_verdict();
        $display("comparisons %0d mismatches %0d", n_tests, error_cnt);
        if (error_cnt == 0 && n_tests > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : give_verdict
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d, input logic err);
        psel <= 1;
        penable <= 0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clock);
        penable <= 1;
        // No cycle count is assumed; only the watchdog ends a hung wait
        do
            @(posedge clock);
        while (pready !== 1'b1);
        rd = prdata;
        check({31'h0, pslverr}, {31'h0, err});
        psel <= 0;
        penable <= 0;
        // One idle edge, so a following call never drives psel twice in one step
        @(posedge clock);
    endtask : apb
    task automatic step(input logic u);
        stepReq <= 1;
        stepUp <= u;
        @(posedge clock);
        stepReq <= 0;
        repeat (gap) @(posedge clock);
        pos = nxt(pos, u);
        vel = nxt(vel, u);
        up = u;
    endtask : step
    initial
    begin
        #(40 * 20000);
        error_cnt++;
        give_verdict();
    end
    // ----------------
    // Main sequence
    // ----------------
    initial
    begin
        repeat (16) @(posedge clock);
        reset <= 0;
        @(posedge clock);
        apb(0, CTRL_OFS, 32'h0, 0);
        check(rd, CTRL_RESET);
        apb(0, 8'h40, 32'h0, 1);
        check(rd, 32'h0);
        apb(1, CTRL_OFS, 32'h1, 0);
        for (i = 0; i < 40; i++)
        begin
            lfsr = rnd(lfsr);
            step(lfsr[0]);
        end
        for (i = 0; i < 4; i++)
            step(1);
        apb(0, POS_OFS, 32'h0, 0);
        check(rd, pos);
        check({31'h0, countDir}, {31'h0, up});
        jumpReq <= 1;
        @(posedge clock);
        jumpReq <= 0;
        repeat (310) @(posedge clock);
        apb(0, POS_OFS, 32'h0, 0);
        check(rd, pos);
        apb(0, STAT_OFS, 32'h0, 0);
        check({31'h0, rd[ST_ERR_BIT]}, 32'h1);
        apb(1, CTRL_OFS, 32'h0000_0801, 0);
        stepReq <= 1;
        stepUp <= 1;
        @(posedge clock);
        stepUp <= 0;
        @(posedge clock);
        stepReq <= 0;
        gap = 20;
        step(0);
        apb(0, POS_OFS, 32'h0, 0);
        check(rd, pos);
        lfsr = rnd(lfsr) & 32'h0FFF_FFFF;
        apb(1, INIT_OFS, lfsr, 0);
        apb(1, CMD_OFS, 32'h1, 0);
        apb(0, POS_OFS, 32'h0, 0);
        check(rd, lfsr);
        pos = lfsr;
        step(1);
        apb(1, CMD_OFS, 32'h2, 0);
        apb(0, INIT_OFS, 32'h0, 0);
        check(rd, pos);
        apb(1, CMPLO_OFS, pos + 32'h5, 0);
        apb(1, CMPHI_OFS, pos + 32'h5, 0);
        apb(1, CMD_OFS, 32'h4, 0);
        apb(0, STAT_OFS, 32'h0, 0);
        check({27'h0, rd[4:0]}, 32'h3);
        apb(0, VEL_OFS, 32'h0, 0);
        check(rd, vel);
        apb(1, CTRL_OFS, 32'h11, 0);
        idxReq <= 1;
        repeat (3) @(posedge clock);
        idxReq <= 0;
        repeat (8) @(posedge clock);
        apb(0, POS_OFS, 32'h0, 0);
        check(rd, 32'h0);
        apb(0, IDXCNT_OFS, 32'h0, 0);
        check(rd, 32'h1);
        apb(1, CTRL_OFS, 32'h9, 0);
        apb(0, TMR_OFS, 32'h0, 0);
        r1 = rd;
        apb(0, TMR_OFS, 32'h0, 0);
        check(rd - r1, 32'h3);
        apb(1, CMPLO_OFS, 32'h8000_0000, 0);
        apb(1, CMPHI_OFS, 32'h7FFF_FFFF, 0);
        apb(1, CMD_OFS, 32'h4, 0);
        apb(0, CMD_OFS, 32'h0, 0);
        check(rd, 32'h0);
        check({30'h0, irq}, 32'h0);
        apb(1, TMR_OFS, 32'hFFFF_FFFE, 0);
        repeat (3) @(posedge clock);
        apb(0, STAT_OFS, 32'h0, 0);
        check({31'h0, rd[ST_CNTEV_BIT]}, 32'h1);
        check({30'h0, irq}, 32'h1);
        apb(1, CTRL_OFS, 32'h7, 0);
        gateIn <= 1;
        repeat (10) @(posedge clock);
        gateIn <= 0;
        apb(0, TMR_OFS, 32'h0, 0);
        check(rd, 32'hA);
        // One line cycle holds exactly one phase A rise, whatever the start state
        apb(1, CTRL_OFS, 32'h3, 0);
        for (i = 0; i < 4; i++)
            step(0);
        apb(0, POS_OFS, 32'h0, 0);
        check(rd, 32'h1);
        apb(1, CTRL_OFS, 32'h5, 0);
        for (i = 0; i < 8; i++)
        begin
            gateIn <= (i >= 4);
            step(0);
        end
        gateIn <= 0;
        apb(0, POS_OFS, 32'h0, 0);
        check(rd, 32'h2);
        apb(1, CTRL_OFS, 32'h0001_0001, 0);
        apb(0, VEL_OFS, 32'h0, 0);
        for (i = 0; i < 3; i++)
            step(1);
        apb(0, VEL_OFS, 32'h0, 0);
        check(rd, 32'h3);
        apb(0, VEL_OFS, 32'h0, 0);
        check(rd, 32'h0);
        homeReq <= 1;
        repeat (4) @(posedge clock);
        homeReq <= 0;
        apb(0, INIT_OFS, 32'h0, 0);
        check(rd, 32'h5);
        check({30'h0, irq}, 32'h3);
        apb(1, CTRL_OFS, 32'hB, 0);
        step(1);
        step(1);
        apb(0, INTVL_OFS, 32'h0, 0);
        check(rd, 32'(gap + 1));
        give_verdict();
    end
endmodule : testbench
`default_nettype wire
